//--- clk_sel_pkg.sv
// constants for the reset clock source selector
package clk_sel_pkg;
   // ***************************************************************
   // source codes, shared by reset code, request and current source
   // ***************************************************************
   localparam logic [2:0] SRC_FAST_64M  = 3'h0;
   localparam logic [2:0] SRC_RSVD_1    = 3'h1;
   localparam logic [2:0] SRC_EXT_PLL   = 3'h2;
   localparam logic [2:0] SRC_RSVD_3    = 3'h3;
   localparam logic [2:0] SRC_SECONDARY = 3'h4;
   localparam logic [2:0] SRC_SLOW_INT  = 3'h5;
   localparam logic [2:0] SRC_FAST_4M   = 3'h6;
   localparam logic [2:0] SRC_EXTERNAL  = 3'h7;

   // ***************************************************************
   // divider and internal frequency codes
   // ***************************************************************
   localparam logic [3:0] DIV_1         = 4'h0;
   localparam logic [3:0] DIV_4         = 4'h2;
   localparam logic [3:0] FRQ_4M        = 4'h2;
   localparam logic [3:0] FRQ_64M       = 4'h8;

   // ***************************************************************
   // external oscillator mode codes
   // ***************************************************************
   localparam logic [1:0] EXT_LOW_PWR   = 2'h0;
   localparam logic [1:0] EXT_MED_PWR   = 2'h1;
   localparam logic [1:0] EXT_HIGH_PWR  = 2'h2;
   localparam logic [1:0] EXT_CRYSTAL   = 2'h3;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS         = 10;
   localparam int OST_PERIODS           = 1024;
   localparam int FAIL_TIME_NS          = 20000;
   // longest silence, rounded down to whole cycles
   localparam int FAIL_CYCLES           = FAIL_TIME_NS / CLK_PERIOD_NS;
   localparam logic [1:0] MON_COUNT_RST = 2'h0;
endpackage

//--- clk_source_select.sv
// clock source selection, start-up timing and failure monitor
// Summary of operation
// - Each reset loads the reset code into new and current source.
// - Code 000 is fast internal 64 MHz, divider 1:1, frequency code 1000.
// - Code 010 is primary external times four, 1:1, frequency code 0010.
// - External choices take low, medium, high power clock or crystal mode.
// - Monitor watches system, primary, secondary; system loss falls back.
// - Software may switch between internal and external while running.
// - The times-four multiplier serves only the primary external source.
// - Start-up timer counts 1024 crystal periods before ready is set.
// - External logic clock modes skip the start-up timer.
`timescale 1ns/1ns
module clk_source_select #(
   parameter int OST_COUNT  = clk_sel_pkg::OST_PERIODS,
   parameter int FAIL_LIMIT = clk_sel_pkg::FAIL_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [2:0] reset_source_code,
   input  wire logic [1:0] ext_osc_mode_select,
   input  wire logic       wake,
   input  wire logic       system_clock_tick,
   input  wire logic       primary_clock_tick,
   input  wire logic       secondary_clock_tick,
   input  wire logic       switch_req,
   input  wire logic [2:0] new_source_request,
   input  wire logic [3:0] new_divider_request,
   input  wire logic       fail_clear,
   output logic [2:0]      new_source_q,
   output logic [3:0]      new_divider_q,
   output logic [2:0]      current_source_q,
   output logic [3:0]      current_divider_q,
   output logic [3:0]      internal_freq_select_q,
   output logic [1:0]      ext_mode_q,
   output logic            pll_enable_q,
   output logic            external_osc_ready_q,
   output logic            secondary_osc_ready_q,
   output logic            switch_busy_q,
   output logic            system_fail_q,
   output logic            primary_fail_q,
   output logic            secondary_fail_q
);
   // ***************************************************************
   // elaboration checks
   // ***************************************************************
   if (OST_COUNT < 1 || OST_COUNT > 65535 ||
       FAIL_LIMIT < 2 || FAIL_LIMIT > 65535) begin : g_bad_param
      $error("OST_COUNT or FAIL_LIMIT out of range");
   end
   localparam logic [15:0] OST_LAST  = 16'(OST_COUNT - 1);
   localparam logic [15:0] FAIL_LAST = 16'(FAIL_LIMIT - 1);
   typedef enum logic [1:0] {SW_IDLE, SW_WAIT} sw_state_t;
   // ***************************************************************
   // helpers
   // ***************************************************************
   // reserved codes are never taken
   function automatic logic code_valid(input logic [2:0] c);
      code_valid = (c != clk_sel_pkg::SRC_RSVD_1) &&
                   (c != clk_sel_pkg::SRC_RSVD_3);
   endfunction
   // sources fed from the primary external pins
   function automatic logic uses_primary(input logic [2:0] c);
      uses_primary = (c == clk_sel_pkg::SRC_EXTERNAL) ||
                     (c == clk_sel_pkg::SRC_EXT_PLL);
   endfunction
   logic            loaded_q;
   logic [2:0]      strap_code;
   logic            ext_logic_mode;
   logic            prim_prev_q, sec_prev_q, sys_prev_q;
   logic            prim_edge, sec_edge, sys_edge;
   logic [15:0]     ost_prim_q;
   logic [15:0]     ost_sec_q;
   logic [15:0]     mon_sys_q, mon_prim_q, mon_sec_q;
   logic            target_ready;
   sw_state_t       sw_state_q;
   // reserved strap falls back to the 64 MHz internal setting
   assign strap_code = code_valid(reset_source_code) ?
                       reset_source_code : clk_sel_pkg::SRC_FAST_64M;
   assign ext_logic_mode = (ext_mode_q != clk_sel_pkg::EXT_CRYSTAL);
   assign prim_edge = primary_clock_tick & ~prim_prev_q;
   assign sec_edge  = secondary_clock_tick & ~sec_prev_q;
   assign sys_edge  = system_clock_tick & ~sys_prev_q;

   // ***************************************************************
   // edge capture of the oscillator activity inputs
   // ***************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prim_prev_q <= 1'b0;
         sec_prev_q  <= 1'b0;
         sys_prev_q  <= 1'b0;
      end else begin
         prim_prev_q <= primary_clock_tick;
         sec_prev_q  <= secondary_clock_tick;
         sys_prev_q  <= system_clock_tick;
      end
   end

   // ***************************************************************
   // one-shot load flag; straps are caught after release, not in reset
   // ***************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         loaded_q <= 1'b0;
      end else begin
         loaded_q <= 1'b1;
      end
   end

   // external mode latched with the reset code
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ext_mode_q <= clk_sel_pkg::EXT_LOW_PWR;
      end else if (!loaded_q) begin
         ext_mode_q <= ext_osc_mode_select;
      end
   end

   // ***************************************************************
   // primary start-up timer
   // ***************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ost_prim_q           <= 16'h0000;
         external_osc_ready_q <= 1'b0;
      end else if (!loaded_q || wake) begin
         // restart after reset or wake
         ost_prim_q           <= 16'h0000;
         external_osc_ready_q <= 1'b0;
      end else if (ext_logic_mode) begin
         external_osc_ready_q <= 1'b1;
      end else if (!external_osc_ready_q && prim_edge) begin
         if (ost_prim_q == OST_LAST) begin
            external_osc_ready_q <= 1'b1;
         end else begin
            ost_prim_q <= ost_prim_q + 16'h0001;
         end
      end
   end

   // secondary oscillator settles the same way, always a crystal count
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ost_sec_q             <= 16'h0000;
         secondary_osc_ready_q <= 1'b0;
      end else if (!loaded_q || wake) begin
         ost_sec_q             <= 16'h0000;
         secondary_osc_ready_q <= 1'b0;
      end else if (!secondary_osc_ready_q && sec_edge) begin
         if (ost_sec_q == OST_LAST) begin
            secondary_osc_ready_q <= 1'b1;
         end else begin
            ost_sec_q <= ost_sec_q + 16'h0001;
         end
      end
   end

   // ***************************************************************
   // activity monitors: silence for FAIL_LIMIT cycles flags a loss
   // ***************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mon_sys_q  <= 16'h0000;
         mon_prim_q <= 16'h0000;
         mon_sec_q  <= 16'h0000;
      end else begin
         mon_sys_q  <= (sys_edge || mon_sys_q == FAIL_LAST) ?
                       16'h0000 : mon_sys_q + 16'h0001;
         mon_prim_q <= (prim_edge || !uses_primary(current_source_q) ||
                        mon_prim_q == FAIL_LAST) ?
                       16'h0000 : mon_prim_q + 16'h0001;
         mon_sec_q  <= (sec_edge ||
                        current_source_q != clk_sel_pkg::SRC_SECONDARY ||
                        mon_sec_q == FAIL_LAST) ?
                       16'h0000 : mon_sec_q + 16'h0001;
      end
   end

   // sticky loss flags; a new loss wins over a clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         system_fail_q    <= 1'b0;
         primary_fail_q   <= 1'b0;
         secondary_fail_q <= 1'b0;
      end else begin
         system_fail_q    <= (mon_sys_q == FAIL_LAST) ||
                             (system_fail_q && !fail_clear);
         primary_fail_q   <= (mon_prim_q == FAIL_LAST) ||
                             (primary_fail_q && !fail_clear);
         secondary_fail_q <= (mon_sec_q == FAIL_LAST) ||
                             (secondary_fail_q && !fail_clear);
      end
   end

   // ***************************************************************
   // source switching
   // ***************************************************************
   // target may be taken once its oscillator has settled
   always_comb begin
      if (uses_primary(new_source_q)) begin
         target_ready = external_osc_ready_q;
      end else if (new_source_q == clk_sel_pkg::SRC_SECONDARY) begin
         target_ready = secondary_osc_ready_q;
      end else begin
         target_ready = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         new_source_q           <= clk_sel_pkg::SRC_FAST_64M;
         new_divider_q          <= clk_sel_pkg::DIV_1;
         current_source_q       <= clk_sel_pkg::SRC_FAST_64M;
         current_divider_q      <= clk_sel_pkg::DIV_1;
         internal_freq_select_q <= clk_sel_pkg::FRQ_64M;
         sw_state_q             <= SW_IDLE;
      end else if (!loaded_q) begin
         // reset code into new and current
         new_source_q     <= strap_code;
         current_source_q <= strap_code;
         sw_state_q       <= SW_IDLE;
         case (strap_code)
            clk_sel_pkg::SRC_FAST_64M: begin
               new_divider_q          <= clk_sel_pkg::DIV_1;
               current_divider_q      <= clk_sel_pkg::DIV_1;
               internal_freq_select_q <= clk_sel_pkg::FRQ_64M;
            end
            clk_sel_pkg::SRC_FAST_4M: begin
               new_divider_q          <= clk_sel_pkg::DIV_4;
               current_divider_q      <= clk_sel_pkg::DIV_4;
               internal_freq_select_q <= clk_sel_pkg::FRQ_4M;
            end
            // external times four, and others undivided
            default: begin
               new_divider_q          <= clk_sel_pkg::DIV_1;
               current_divider_q      <= clk_sel_pkg::DIV_1;
               internal_freq_select_q <= clk_sel_pkg::FRQ_4M;
            end
         endcase
      end else if (system_fail_q &&
                   current_source_q != clk_sel_pkg::SRC_FAST_4M) begin
         // fall back to fast internal, pending switch dropped
         current_source_q <= clk_sel_pkg::SRC_FAST_4M;
         new_source_q     <= clk_sel_pkg::SRC_FAST_4M;
         sw_state_q       <= SW_IDLE;
      end else begin
         case (sw_state_q)
            SW_IDLE: begin
               if (switch_req && code_valid(new_source_request)) begin
                  new_source_q  <= new_source_request;
                  new_divider_q <= new_divider_request;
                  sw_state_q    <= SW_WAIT;
               end
            end
            SW_WAIT: begin
               // hold the old clock until the new one has settled
               if (target_ready) begin
                  current_source_q  <= new_source_q;
                  current_divider_q <= new_divider_q;
                  sw_state_q        <= SW_IDLE;
               end
            end
            default: begin
               sw_state_q <= SW_IDLE;
            end
         endcase
      end
   end

   // busy flag registered so the output stays a flop
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         switch_busy_q <= 1'b0;
      end else begin
         switch_busy_q <= (sw_state_q == SW_WAIT) && !target_ready &&
                          !system_fail_q;
      end
   end

   // multiplier only ever follows the primary external pins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pll_enable_q <= 1'b0;
      end else begin
         pll_enable_q <= loaded_q &&
                         (current_source_q == clk_sel_pkg::SRC_EXT_PLL);
      end
   end
endmodule

//--- ext_clock_model.sv
// far-side model of the system, primary and secondary clock sources
`timescale 1ns/1ns
module ext_clock_model (
   input  wire logic clk,
   input  wire logic sys_run,
   input  wire logic pri_run,
   input  wire logic sec_run,
   output logic      sys_tick,
   output logic      pri_tick,
   output logic      sec_tick
);
   logic [1:0] phase_q = 2'h0;
   // shared phase, divide by four for system and primary, by two for secondary, well inside the silence limit
   always @(posedge clk) begin
      phase_q <= phase_q + 2'h1;
   end
   // a stopped source sits low, as a dead oscillator pin would
   always @(posedge clk) begin
      sys_tick <= sys_run & phase_q[1];
      pri_tick <= pri_run & phase_q[1];
      sec_tick <= sec_run & phase_q[0];
   end
endmodule

//--- clk_source_select_props.sv
// concurrent checks on the clock source selector ports
`timescale 1ns/1ns
module clk_source_select_props #(
   parameter int OST_COUNT  = 4,
   parameter int FAIL_LIMIT = 16
) (
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic [2:0] reset_source_code,
   input wire logic [1:0] ext_osc_mode_select,
   input wire logic       wake,
   input wire logic       primary_clock_tick,
   input wire logic       switch_req,
   input wire logic [2:0] new_source_request,
   input wire logic [3:0] new_divider_request,
   input wire logic [2:0] new_source_q,
   input wire logic [3:0] new_divider_q,
   input wire logic [2:0] current_source_q,
   input wire logic [3:0] current_divider_q,
   input wire logic [3:0] internal_freq_select_q,
   input wire logic [1:0] ext_mode_q,
   input wire logic       pll_enable_q,
   input wire logic       external_osc_ready_q,
   input wire logic       switch_busy_q,
   input wire logic       system_fail_q
);
   logic [11:0] pri_edges_q;
   logic        pri_prev_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // primary edges since reset or wake, saturating
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pri_edges_q <= 12'h000;
         pri_prev_q  <= 1'h0;
      end else begin
         pri_prev_q <= primary_clock_tick;
         if (wake)
            pri_edges_q <= 12'h000;
         else if (primary_clock_tick && !pri_prev_q && pri_edges_q != 12'hfff)
            pri_edges_q <= pri_edges_q + 12'h001;
      end
   end
   // reserved straps fall back to the fast internal source
   function automatic logic [2:0] map_code(input logic [2:0] c);
      return (c == 3'h1 || c == 3'h3) ? 3'h0 : c;
   endfunction
   sequence s_first;
      nrst && $past(nrst) && !$past(nrst, 2);
   endsequence
   sequence s_take;
      switch_req && !switch_busy_q && !system_fail_q &&
         new_source_request != 3'h1 && new_source_request != 3'h3;
   endsequence
   property p_load;
      s_first |-> current_source_q == map_code($past(reset_source_code))
         && new_source_q == current_source_q;
   endproperty
   property p_divfrq;
      s_first |-> current_divider_q == (current_source_q == 3'h6 ? 4'h2 : 4'h0)
         && internal_freq_select_q == (current_source_q == 3'h0 ? 4'h8 : 4'h2);
   endproperty
   property p_mode;
      s_first |-> ext_mode_q == $past(ext_osc_mode_select);
   endproperty
   property p_pll;
      $past(nrst) |-> pll_enable_q == ($past(current_source_q) == 3'h2);
   endproperty
   property p_take;
      s_take |=> new_source_q == $past(new_source_request)
         && new_divider_q == $past(new_divider_request);
   endproperty
   property p_int_switch;
      s_take ##0 new_source_request inside {3'h0, 3'h5, 3'h6}
         |-> ##2 current_source_q == $past(new_source_request, 2);
   endproperty
   property p_refuse;
      switch_req && !system_fail_q && new_source_request == 3'h3
         |=> $stable(new_source_q);
   endproperty
   property p_ost;
      $rose(external_osc_ready_q) && ext_mode_q == 2'h3
         |-> pri_edges_q >= OST_COUNT;
   endproperty
   property p_logic_ready;
      s_first ##0 ext_mode_q != 2'h3 && !wake |=> external_osc_ready_q;
   endproperty
   property p_fallback;
      $rose(system_fail_q) |-> ##[0:1]
         (current_source_q == 3'h6 && new_source_q == 3'h6);
   endproperty
   a_load: assert property (p_load) else $error("strap load wrong");
   a_divfrq: assert property (p_divfrq) else $error("div wrong");
   a_mode: assert property (p_mode) else $error("mode latch wrong");
   a_pll: assert property (p_pll) else $error("multiplier misuse");
   a_take: assert property (p_take) else $error("request lost");
   a_int_switch: assert property (p_int_switch) else $error("stuck");
   a_refuse: assert property (p_refuse) else $error("reserved");
   a_ost: assert property (p_ost) else $error("ready too early");
   a_logic_ready: assert property (p_logic_ready) else $error("late");
   a_fallback: assert property (p_fallback) else $error("stayed");
   c_take: cover property (s_take);
   c_fail: cover property ($rose(system_fail_q));
   c_ost: cover property ($rose(external_osc_ready_q) && ext_mode_q == 2'h3);
endmodule

bind clk_source_select clk_source_select_props #(
   .OST_COUNT(OST_COUNT), .FAIL_LIMIT(FAIL_LIMIT)) u_props (
   .clk(clk), .nrst(nrst), .reset_source_code(reset_source_code),
   .ext_osc_mode_select(ext_osc_mode_select), .wake(wake),
   .primary_clock_tick(primary_clock_tick), .switch_req(switch_req),
   .new_source_request(new_source_request),
   .new_divider_request(new_divider_request), .new_source_q(new_source_q),
   .new_divider_q(new_divider_q), .current_source_q(current_source_q),
   .current_divider_q(current_divider_q), .ext_mode_q(ext_mode_q),
   .internal_freq_select_q(internal_freq_select_q),
   .pll_enable_q(pll_enable_q), .external_osc_ready_q(external_osc_ready_q),
   .switch_busy_q(switch_busy_q), .system_fail_q(system_fail_q));

//--- reset_clock_source_select_bench.sv
// self-checking bench for the clock source selector
`timescale 1ns/1ns
module reset_clock_source_select_bench;
   localparam int OST_N = 4;
   logic       clk = 1'h0, nrst = 1'h0, wake = 1'h0, fail_clear = 1'h0;
   logic       switch_req = 1'h0, sys_run = 1'h1, pri_run = 1'h1;
   logic       sec_run = 1'h1;
   logic [2:0] strap_code = 3'h0, req_src = 3'h0;
   logic [1:0] strap_mode = 2'h0;
   logic [3:0] req_div = 4'h0;
   logic       sys_tick, pri_tick, sec_tick;
   logic [2:0] new_source_q, current_source_q;
   logic [3:0] new_divider_q, current_divider_q, internal_freq_select_q;
   logic [1:0] ext_mode_q;
   logic       pll_enable_q, external_osc_ready_q, secondary_osc_ready_q;
   logic       switch_busy_q, system_fail_q, primary_fail_q, secondary_fail_q;
   int         n_mismatch = 0, check_count = 0, cycles = 0, n;
   logic       last;
   always #5 clk = ~clk;
   ext_clock_model u_src (.clk(clk), .sys_run(sys_run), .pri_run(pri_run),
      .sec_run(sec_run), .sys_tick(sys_tick), .pri_tick(pri_tick),
      .sec_tick(sec_tick));
   clk_source_select #(.OST_COUNT(OST_N), .FAIL_LIMIT(16)) u_dut (
      .clk(clk), .nrst(nrst), .reset_source_code(strap_code),
      .ext_osc_mode_select(strap_mode), .wake(wake),
      .system_clock_tick(sys_tick), .primary_clock_tick(pri_tick),
      .secondary_clock_tick(sec_tick), .switch_req(switch_req),
      .new_source_request(req_src), .new_divider_request(req_div),
      .fail_clear(fail_clear), .new_source_q(new_source_q),
      .new_divider_q(new_divider_q), .current_source_q(current_source_q),
      .current_divider_q(current_divider_q), .ext_mode_q(ext_mode_q),
      .internal_freq_select_q(internal_freq_select_q),
      .pll_enable_q(pll_enable_q),
      .external_osc_ready_q(external_osc_ready_q),
      .secondary_osc_ready_q(secondary_osc_ready_q),
      .switch_busy_q(switch_busy_q), .system_fail_q(system_fail_q),
      .primary_fail_q(primary_fail_q), .secondary_fail_q(secondary_fail_q));
   // **************************
   // access and compare tasks
   // **************************
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk_val(input string nm, input logic [3:0] got, exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic chk_flag(input string nm, input logic got, exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %b seen %b", nm, exp, got);
      end
   endtask
   // reset is held ten cycles, straps settle well before release
   task automatic do_reset(input logic [2:0] code, input logic [1:0] mode);
      @(posedge clk);
      nrst       <= 1'h0;
      strap_code <= code;
      strap_mode <= mode;
      repeat (10) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      @(negedge clk);
   endtask
   // one-cycle request pulse, then look after the taking edge
   task automatic switch_to(input logic [2:0] src, input logic [3:0] div);
      @(posedge clk);
      switch_req <= 1'h1;
      req_src    <= src;
      req_div    <= div;
      @(posedge clk);
      switch_req <= 1'h0;
      @(negedge clk);
   endtask
   // clear pulse driven on rising edges, seen at the second one
   task automatic clear_fails();
      @(posedge clk);
      fail_clear <= 1'h1;
      @(posedge clk);
      fail_clear <= 1'h0;
   endtask
   // hang guard, far above the few hundred cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         results();
      end
   end
   // **************************
   // main sequence
   // **************************
   initial begin
      for (int c = 0; c < 8; c++) begin
         do_reset(3'(c), 2'(c));
         n = (c == 1 || c == 3) ? 0 : c;
         chk_val("new_src", 4'(new_source_q), 4'(n));
         chk_val("cur_src", 4'(current_source_q), 4'(n));
         chk_val("cur_div", current_divider_q, n==6 ? 4'h2 : 4'h0);
         chk_val("new_div", new_divider_q, n == 6 ? 4'h2 : 4'h0);
         chk_val("freq", internal_freq_select_q, n==0 ? 4'h8 : 4'h2);
         chk_val("mode", 4'(ext_mode_q), 4'(c % 4));
         repeat (2) @(negedge clk);
         chk_flag("pll", pll_enable_q, n == 2);
         chk_flag("ext_ready", external_osc_ready_q, c % 4 != 3);
      end
      // crystal start-up with the primary held silent first
      pri_run <= 1'h0;
      do_reset(3'h7, 2'h3);
      repeat (40) @(negedge clk);
      chk_flag("ext_ready", external_osc_ready_q, 1'h0);
      chk_flag("pri_fail", primary_fail_q, 1'h1);
      chk_flag("sec_ready", secondary_osc_ready_q, 1'h1);
      pri_run <= 1'h1;
      n = 0;
      last = 1'h0;
      for (int i = 0; i < 200 && external_osc_ready_q !== 1'h1; i++) begin
         @(negedge clk);
         if (pri_tick && !last)
            n++;
         last = pri_tick;
      end
      chk_val("ost_edges", 4'(n), 4'(OST_N));
      clear_fails();
      @(negedge clk);
      chk_flag("pri_fail", primary_fail_q, 1'h0);
      // wake restarts both settling counts
      @(posedge clk);
      wake <= 1'h1;
      @(posedge clk);
      wake <= 1'h0;
      @(negedge clk);
      chk_flag("ext_ready", external_osc_ready_q, 1'h0);
      chk_flag("sec_ready", secondary_osc_ready_q, 1'h0);
      // run-time switch external to internal and back through the pll
      switch_to(3'h5, 4'h3);
      chk_val("new_src", 4'(new_source_q), 4'h5);
      chk_val("new_div", new_divider_q, 4'h3);
      @(negedge clk);
      chk_val("cur_src", 4'(current_source_q), 4'h5);
      chk_val("cur_div", current_divider_q, 4'h3);
      switch_to(3'h2, 4'h0);
      // the crystal is still settling after the wake, old source held
      @(negedge clk);
      chk_flag("busy", switch_busy_q, 1'h1);
      chk_val("cur_src", 4'(current_source_q), 4'h5);
      for (int i = 0; i < 100 && current_source_q !== 3'h2; i++)
         @(negedge clk);
      repeat (2) @(negedge clk);
      chk_flag("pll", pll_enable_q, 1'h1);
      for (int i = 0; i < 100 && switch_busy_q !== 1'h0; i++) @(negedge clk);
      switch_to(3'h3, 4'h1);
      chk_val("new_src", 4'(new_source_q), 4'h2);
      // system clock loss forces the internal fallback
      sys_run <= 1'h0;
      for (int i = 0; i < 100 && system_fail_q !== 1'h1; i++) @(negedge clk);
      @(negedge clk);
      chk_flag("sys_fail", system_fail_q, 1'h1);
      chk_val("cur_src", 4'(current_source_q), 4'h6);
      chk_val("new_src", 4'(new_source_q), 4'h6);
      chk_val("cur_div", current_divider_q, 4'h0);
      sys_run <= 1'h1;
      // secondary loss is only watched while it drives the system
      repeat (8) @(negedge clk);
      clear_fails();
      @(negedge clk);
      chk_flag("sys_fail", system_fail_q, 1'h0);
      switch_to(3'h4, 4'h0);
      for (int i = 0; i < 100 && current_source_q !== 3'h4; i++)
         @(negedge clk);
      sec_run <= 1'h0;
      for (int i = 0; i < 100 && secondary_fail_q !== 1'h1; i++)
         @(negedge clk);
      chk_flag("sec_fail", secondary_fail_q, 1'h1);
      chk_val("cur_src", 4'(current_source_q), 4'h4);
      results();
   end
endmodule
